// >>> hw/line_term_regs.vh
/*
 * Constants of the line-termination activation machine: state codes,
 * transmit line signal codes and timer durations.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LINE_TERM_REGS_VH
`define LINE_TERM_REGS_VH

// State codes
`define ST_DEACTIVATED    4'h0
`define ST_AWAKE_ACK      4'h1
`define ST_AWAKE_SEND     4'h2
`define ST_TRAINING       4'h3
`define ST_LINE_SYNCED    4'h4
`define ST_PREACTIVE      4'h5
`define ST_FULL_ACTIVE    4'h6
`define ST_PENDING_DEACT  4'h7
`define ST_LOOP_WAKE      4'h8
`define ST_LOOP_SYNC      4'h9
`define ST_LOOP_PREACTIVE 4'hA
`define ST_LOOP_ACTIVE    4'hB

// Transmitted line signal codes
`define TX_QUIET          3'h0
`define TX_LOCAL_WAKE     3'h1
`define TX_TRAINING       3'h2
`define TX_PRE_ACTIVE     3'h3
`define TX_ACTIVE         3'h4

// Timer durations in microseconds, and the clock rate
`define CLK_MHZ           125
`define WAKE_ACK_US       1000
`define PREACTIVE_HOLD_US 1000
`define LOOP_WAKE_US      1000

// Cycle counts derived from the durations
`define WAKE_ACK_CYC       (`WAKE_ACK_US * `CLK_MHZ)
`define PREACTIVE_HOLD_CYC (`PREACTIVE_HOLD_US * `CLK_MHZ)
`define LOOP_WAKE_CYC      (`LOOP_WAKE_US * `CLK_MHZ)

// Activation time budgets in milliseconds
`define ACT_AFTER_DEACT_MS     210
`define ACT_AFTER_DEACT_REG_MS 420
`define ACT_FIRST_POWER_MS     1500
`define ACT_FIRST_POWER_REG_MS 3000

`endif

// >>> hw/act_timer.v
/*
 * One-shot down-counting timer with a start strobe and an expiry pulse.
 * Assumes start comes from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module act_timer #(
    parameter WIDTH = 24
) (
    input  wire             core_clk_i,
    input  wire             rst_i,
    input  wire             start_i,
    input  wire [WIDTH-1:0] load_i,
    output reg              expire_o
);

    reg [WIDTH-1:0] count_q;
    reg             run_q;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q  <= {WIDTH{1'b0}};
            run_q    <= 1'b0;
            expire_o <= 1'b0;
        end else if (start_i) begin
            // Restart reloads the full duration
            count_q  <= load_i;
            run_q    <= 1'b1;
            expire_o <= 1'b0;
        end else if (run_q && count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            run_q    <= 1'b0;
            expire_o <= 1'b1;
        end else begin
            count_q  <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
            expire_o <= 1'b0;
        end
    end

endmodule // act_timer

`default_nettype wire

// >>> hw/line_term_activation_fsm.v
/*
 * Activation and deactivation state machine of the line-termination end
 * of a subscriber line system, with loop-1 loopback activation.
 * Assumes receiver status inputs are async and are synchronised here;
 * exchange-side requests come from logic on the same clock as pulses.
 */
// How it works
// [R1] Transmitted line signal fixed by current state
// [R2] Activate request in deactivated: send wake
// [R3] Remote wake: acknowledge or go training
// [R4] Wake-ack expiry moves only awake-ack state
// [R5] Synced with remote training: line synced
// [R6] Remote interface synced: start hold, preactive
// [R7] Hold expiry: fully active, activated indication
// [R8] Deactivate request: pending deactivation from every state but deactivated and pending deactivation
// [R9] Line quiet when synced: error, or deactivated on pending
// [R10] Framing loss when synced: line error
// [R11] Loop request: loop wake or loop sync
// [R12] Loop wake sends wake, expiry to sync
// [R13] Loop sync achieved: hold timer, loop preactive
// [R14] Loop hold expiry: activated, loop active
// [R15] Loop active: transmit active, loopback operated
// [R16] Loop 2 and 1A leave machine unchanged
// [R17] Re-activation completes within 210/420 ms
// [R18] First-power activation within 1.5/3 s
// [R19] Unlisted events change nothing
`timescale 1ns/100ps
`default_nettype none
`include "line_term_regs.vh"

module line_term_activation_fsm #(
    // Timer lengths bound the activation time; see [R17] [R18]
    parameter WAKE_ACK_CYCLES  = `WAKE_ACK_CYC,
    parameter PREACT_CYCLES    = `PREACTIVE_HOLD_CYC,
    parameter LOOP_WAKE_CYCLES = `LOOP_WAKE_CYC,
    parameter LOOP_TO_SYNC     = 1
) (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire       activate_request_element_i,
    input  wire       deactivate_request_element_i,
    input  wire       loop1_request_element_i,
    input  wire       remote_wake_signal_i,
    input  wire       remote_training_i,
    input  wire       remote_if_synced_i,
    input  wire       line_quiet_i,
    input  wire       rx_synced_i,
    input  wire       framing_lost_i,
    input  wire       loop_rx_synced_i,
    output reg  [2:0] tx_signal_o,
    output reg  [3:0] state_o,
    output reg        loopback1_o,
    output reg        wake_seen_indication_o,
    output reg        line_synced_indication_o,
    output reg        activated_indication_o,
    output reg        deactivated_indication_o,
    output reg        line_error_indication_o
);

    localparam TW = 24;

    // Two-flop synchronisers for line receiver status
    reg [6:0] meta_q;
    reg [6:0] sync_q;
    reg [6:0] prev_q;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 7'h00;
            sync_q <= 7'h00;
            prev_q <= 7'h00;
        end else begin
            meta_q <= {remote_wake_signal_i, remote_training_i,
                       remote_if_synced_i, line_quiet_i, rx_synced_i,
                       framing_lost_i, loop_rx_synced_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    wire rx_wake     = sync_q[6];
    wire rx_training = sync_q[5];
    wire rx_ifsync   = sync_q[4];
    wire rx_quiet    = sync_q[3];
    wire rx_synced   = sync_q[2];
    wire lost_frame  = sync_q[1];
    wire loop_synced = sync_q[0];
    // Events are rising edges of the synchronised levels
    wire wake_ev     = rx_wake & ~prev_q[6];
    wire quiet_ev    = rx_quiet & ~prev_q[3];
    wire lost_ev     = lost_frame & ~prev_q[1];

    reg  [3:0] state_q;
    reg  [3:0] state_d;
    reg        start_wa;
    reg        start_ph;
    reg        start_lw;
    reg        ind_wake;
    reg        ind_sync;
    reg        ind_act;
    reg        ind_deact;
    reg        ind_err;
    wire       wa_exp;
    wire       ph_exp;
    wire       lw_exp;

    act_timer #(.WIDTH(TW)) u_wake_ack (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (start_wa),
        .load_i     (WAKE_ACK_CYCLES[TW-1:0]),
        .expire_o   (wa_exp)
    );

    act_timer #(.WIDTH(TW)) u_preact_hold (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (start_ph),
        .load_i     (PREACT_CYCLES[TW-1:0]),
        .expire_o   (ph_exp)
    );

    act_timer #(.WIDTH(TW)) u_loop_wake (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (start_lw),
        .load_i     (LOOP_WAKE_CYCLES[TW-1:0]),
        .expire_o   (lw_exp)
    );

    function [2:0] tx_of;  // see [R1]
        input [3:0] st;
        begin
            case (st)
                `ST_AWAKE_ACK, `ST_AWAKE_SEND, `ST_LOOP_WAKE:
                    tx_of = `TX_LOCAL_WAKE;
                `ST_TRAINING, `ST_LINE_SYNCED, `ST_LOOP_SYNC:
                    tx_of = `TX_TRAINING;
                `ST_PREACTIVE, `ST_LOOP_PREACTIVE:
                    tx_of = `TX_PRE_ACTIVE;
                `ST_FULL_ACTIVE, `ST_LOOP_ACTIVE:
                    tx_of = `TX_ACTIVE;
                default:
                    tx_of = `TX_QUIET;
            endcase
        end
    endfunction

    // Loop 2 and 1A requests have no input here at all; see [R16]
    always @* begin
        state_d   = state_q;  // see [R19]
        start_wa  = 1'b0;
        start_ph  = 1'b0;
        start_lw  = 1'b0;
        ind_wake  = 1'b0;
        ind_sync  = 1'b0;
        ind_act   = 1'b0;
        ind_deact = 1'b0;
        ind_err   = 1'b0;
        if (deactivate_request_element_i &&
            state_q != `ST_DEACTIVATED &&
            state_q != `ST_PENDING_DEACT) begin
            state_d = `ST_PENDING_DEACT;  // see [R8]
        end else begin
            case (state_q)
                `ST_DEACTIVATED: begin
                    if (loop1_request_element_i) begin
                        start_lw = 1'b1;  // see [R11]
                        state_d  = `ST_LOOP_WAKE;
                    end else if (wake_ev) begin
                        start_wa = 1'b1;  // see [R3]
                        ind_wake = 1'b1;
                        state_d  = `ST_AWAKE_ACK;
                    end else if (activate_request_element_i) begin
                        state_d = `ST_AWAKE_SEND;  // see [R2]
                    end
                end
                `ST_AWAKE_ACK: begin
                    if (wa_exp)
                        state_d = `ST_TRAINING;  // see [R4]
                end
                `ST_AWAKE_SEND: begin
                    if (loop1_request_element_i && LOOP_TO_SYNC != 0)
                        state_d = `ST_LOOP_SYNC;  // see [R11]
                    else if (wake_ev)
                        state_d = `ST_TRAINING;  // see [R3]
                end
                `ST_TRAINING: begin
                    if (loop1_request_element_i && LOOP_TO_SYNC != 0) begin
                        state_d = `ST_LOOP_SYNC;  // see [R11]
                    end else if (rx_ifsync) begin
                        start_ph = 1'b1;  // see [R6]
                        state_d  = `ST_PREACTIVE;
                    end else if (rx_synced && rx_training) begin
                        ind_sync = 1'b1;  // see [R5]
                        state_d  = `ST_LINE_SYNCED;
                    end
                end
                `ST_LINE_SYNCED: begin
                    if (loop1_request_element_i && LOOP_TO_SYNC != 0) begin
                        state_d = `ST_LOOP_SYNC;  // see [R11]
                    end else if (rx_ifsync) begin
                        start_ph = 1'b1;  // see [R6]
                        state_d  = `ST_PREACTIVE;
                    end
                end
                `ST_PREACTIVE: begin
                    if (ph_exp) begin
                        ind_act = 1'b1;  // see [R7]
                        state_d = `ST_FULL_ACTIVE;
                    end
                end
                `ST_PENDING_DEACT: begin
                    if (loop1_request_element_i) begin
                        state_d = `ST_LOOP_WAKE;  // see [R11]
                    end else if (quiet_ev || rx_quiet) begin
                        ind_deact = 1'b1;  // see [R9]
                        state_d   = `ST_DEACTIVATED;
                    end
                end
                `ST_LOOP_WAKE: begin
                    if (lw_exp)
                        state_d = `ST_LOOP_SYNC;  // see [R12]
                end
                `ST_LOOP_SYNC: begin
                    if (loop_synced) begin
                        start_ph = 1'b1;  // see [R13]
                        state_d  = `ST_LOOP_PREACTIVE;
                    end
                end
                `ST_LOOP_PREACTIVE: begin
                    if (ph_exp) begin
                        ind_act = 1'b1;  // see [R14]
                        state_d = `ST_LOOP_ACTIVE;
                    end
                end
                default: state_d = state_q;
            endcase
            if ((state_q == `ST_LINE_SYNCED || state_q == `ST_PREACTIVE ||
                 state_q == `ST_FULL_ACTIVE) && (quiet_ev || lost_ev))
                ind_err = 1'b1;  // see [R9] [R10]
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q                  <= `ST_DEACTIVATED;
            state_o                  <= `ST_DEACTIVATED;
            tx_signal_o              <= `TX_QUIET;
            loopback1_o              <= 1'b0;
            wake_seen_indication_o   <= 1'b0;
            line_synced_indication_o <= 1'b0;
            activated_indication_o   <= 1'b0;
            deactivated_indication_o <= 1'b0;
            line_error_indication_o  <= 1'b0;
        end else begin
            state_q                  <= state_d;
            state_o                  <= state_d;
            tx_signal_o              <= tx_of(state_d);  // see [R1] [R12]
            loopback1_o              <= (state_d == `ST_LOOP_SYNC ||
                                         state_d == `ST_LOOP_PREACTIVE ||
                                         state_d == `ST_LOOP_ACTIVE);
            wake_seen_indication_o   <= ind_wake;
            line_synced_indication_o <= ind_sync;
            activated_indication_o   <= ind_act;  // see [R7] [R14]
            deactivated_indication_o <= ind_deact;
            line_error_indication_o  <= ind_err;
        end
    end

endmodule // line_term_activation_fsm

`default_nettype wire

// >>> dv/line_term_fsm_chk.sv
/* Concurrent checks on the ports of the line-termination activation
   machine. Assumes it is bound to the machine from the bench top. */
`timescale 1ns/100ps
`default_nettype none
`include "line_term_regs.vh"
module line_term_fsm_chk #(
    parameter WAKE_ACK_CYCLES  = 8,
    parameter PREACT_CYCLES    = 8,
    parameter LOOP_WAKE_CYCLES = 8
) (
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic       activate_request_element_i,
    input wire logic       deactivate_request_element_i,
    input wire logic       loop1_request_element_i,
    input wire logic       remote_wake_signal_i,
    input wire logic       framing_lost_i,
    input wire logic [2:0] tx_signal_o,
    input wire logic [3:0] state_o,
    input wire logic       loopback1_o,
    input wire logic       activated_indication_o,
    input wire logic       deactivated_indication_o,
    input wire logic       line_error_indication_o
);
    logic [3:0] st_q;
    int         dwell_q;
    wire logic [2:0] tx_exp = state_o inside {0, 7} ? `TX_QUIET :
        state_o inside {1, 2, 8} ? `TX_LOCAL_WAKE :
        state_o inside {3, 4, 9} ? `TX_TRAINING :
        state_o inside {5, 10} ? `TX_PRE_ACTIVE : `TX_ACTIVE;
    // Cycles spent in the current state, for the timer windows
    always @(posedge core_clk_i or posedge rst_i)
        if (rst_i) begin
            st_q <= 4'h0;
            dwell_q <= 0;
        end else begin
            st_q <= state_o;
            dwell_q <= (state_o != st_q) ? 0 : dwell_q + 1;
        end
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_dwell(logic [3:0] a, logic [3:0] b, int n);
        st_q == a && state_o == b |-> dwell_q inside {[n-3:n+3]};
    endproperty
    a_tx_by_state: assert property (tx_signal_o == tx_exp)
        else $error("transmitted signal does not suit state");
    a_act_wakes: assert property ((!remote_wake_signal_i)[*4] ##0
        (state_o == 4'h0 && activate_request_element_i &&
        !deactivate_request_element_i && !loop1_request_element_i)
        |=> state_o == 4'h2) else $error("activate did not wake");
    a_wake_ack_time: assert property (
        p_dwell(1, 3, WAKE_ACK_CYCLES))
        else $error("wake acknowledge wait wrong");
    a_hold_time: assert property (p_dwell(5, 6, PREACT_CYCLES))
        else $error("pre-active hold wrong");
    a_loop_wake_time: assert property (
        p_dwell(8, 9, LOOP_WAKE_CYCLES))
        else $error("loop wake wait wrong");
    a_act_ind: assert property (st_q != state_o &&
        state_o inside {6, 11} |-> ##[0:1] activated_indication_o)
        else $error("activated indication missing");
    a_deact_pend: assert property (deactivate_request_element_i &&
        !(state_o inside {0, 7}) |=> state_o == 4'h7)
        else $error("deactivate not taken");
    a_quiet_deact: assert property (st_q == 4'h7 &&
        state_o == 4'h0 |-> ##[0:1] deactivated_indication_o)
        else $error("deactivated indication missing");
    a_frame_err: assert property ($rose(framing_lost_i) &&
        state_o == 4'h6 |-> ##[1:5] line_error_indication_o)
        else $error("line error missing on framing loss");
    a_loop_level: assert property (loopback1_o ==
        (state_o inside {9, 10, 11})) else $error("loopback level wrong");
    c_full_active: cover property (st_q == 4'h5 && state_o == 4'h6);
    c_loop_active: cover property (st_q == 4'hA && state_o == 4'hB);
    c_back_deact: cover property (st_q == 4'h7 && state_o == 4'h0);
endmodule // line_term_fsm_chk
`default_nettype wire

// >>> dv/remote_nt_model.sv
/* Remote network-termination unit across the line, behavioural.
   Answers the local signal after a delay set by the bench. */
`timescale 1ns/100ps
`default_nettype none
`include "line_term_regs.vh"
module remote_nt_model (
    input  wire logic       core_clk_i,
    input  wire logic [2:0] tx_i,
    input  wire logic       loopback1_i,
    input  wire logic       wake_req_i,
    input  wire logic       quiet_req_i,
    input  wire logic [7:0] dly_i,
    output wire logic       remote_wake_o,
    output wire logic       remote_training_o,
    output wire logic       remote_if_synced_o,
    output wire logic       line_quiet_o,
    output wire logic       rx_synced_o,
    output wire logic       loop_rx_synced_o
);
    logic [2:0] tx_q = 3'h0;
    int         cnt_q = 0;
    wire logic  up = cnt_q >= int'(dly_i);
    wire logic  trn = tx_i == `TX_TRAINING && !loopback1_i;
    // Each answer restarts its delay when the local signal changes
    always @(posedge core_clk_i) begin
        tx_q <= tx_i;
        cnt_q <= (tx_i != tx_q) ? 0 : cnt_q + 1;
    end
    assign remote_wake_o = wake_req_i || (tx_i == `TX_LOCAL_WAKE && up);
    assign remote_training_o = trn && up;
    assign rx_synced_o = trn && up;
    assign remote_if_synced_o = trn && cnt_q >= 2 * int'(dly_i);
    assign line_quiet_o = quiet_req_i ||
        (tx_i == `TX_QUIET && up && !wake_req_i);
    assign loop_rx_synced_o = loopback1_i && up;
endmodule // remote_nt_model
`default_nettype wire

// >>> dv/tb_top.sv
/* Self-checking bench of the line-termination activation machine.
   Assumes the checker and the remote unit model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] req = 3'h0;
    logic       wake_req = 1'b0;
    logic       quiet_req = 1'b0;
    logic       frm_lost = 1'b0;
    logic [7:0] dly = 8'h06;
    logic [3:0] cur = 4'h0;
    wire  [2:0] tx;
    wire  [3:0] st;
    wire  [4:0] ind;
    wire        lb1, r_wake, r_trn, r_ifs, r_quiet, r_sync, r_lsync;
    int         n_errors = 0;
    int         n_compared = 0;
    int         got [5];
    int         xp [5];
    always #4 clk = ~clk;
    always @(posedge clk)
        for (int j = 0; j < 5; j++) got[j] <= got[j] + int'(ind[j]);
    line_term_activation_fsm #(
        .WAKE_ACK_CYCLES (8),
        .PREACT_CYCLES   (8),
        .LOOP_WAKE_CYCLES(8)
    ) line_term_activation_fsm_inst (
        .core_clk_i                  (clk),
        .rst_i                       (rst),
        .activate_request_element_i  (req[0]),
        .deactivate_request_element_i(req[1]),
        .loop1_request_element_i     (req[2]),
        .remote_wake_signal_i        (r_wake),
        .remote_training_i           (r_trn),
        .remote_if_synced_i          (r_ifs),
        .line_quiet_i                (r_quiet),
        .rx_synced_i                 (r_sync),
        .framing_lost_i              (frm_lost),
        .loop_rx_synced_i            (r_lsync),
        .tx_signal_o                 (tx),
        .state_o                     (st),
        .loopback1_o                 (lb1),
        .wake_seen_indication_o      (ind[0]),
        .line_synced_indication_o    (ind[1]),
        .activated_indication_o      (ind[2]),
        .deactivated_indication_o    (ind[3]),
        .line_error_indication_o     (ind[4])
    );
    remote_nt_model remote_nt_model_inst (
        .core_clk_i        (clk),
        .tx_i              (tx),
        .loopback1_i       (lb1),
        .wake_req_i        (wake_req),
        .quiet_req_i       (quiet_req),
        .dly_i             (dly),
        .remote_wake_o     (r_wake),
        .remote_training_o (r_trn),
        .remote_if_synced_o(r_ifs),
        .line_quiet_o      (r_quiet),
        .rx_synced_o       (r_sync),
        .loop_rx_synced_o  (r_lsync)
    );
    task automatic tally_and_finish;
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic pulse(input int k);
        @(negedge clk);
        req[k] = 1'b1;
        @(negedge clk);
        req[k] = 1'b0;
    endtask
    // Model step: next expected state and the indication it brings
    task automatic go(input logic [3:0] e);
        for (int i = 0; i < 800 && st === cur; i++) @(negedge clk);
        `CHK("state", e, st)
        if (cur == 4'h0 && e == 4'h1) xp[0]++;
        if (cur == 4'h3 && e == 4'h4) xp[1]++;
        if (e == 4'h6 || e == 4'hB) xp[2]++;
        if (cur == 4'h7 && e == 4'h0) xp[3]++;
        cur = e;
    endtask
    task automatic walk(input logic [3:0] q[$]);
        foreach (q[i]) go(q[i]);
    endtask
    task automatic hold(input int c);
        repeat (c) @(negedge clk);
        `CHK("state held", cur, st)
    endtask
    task automatic chk_ind;
        repeat (2) @(negedge clk);
        for (int j = 0; j < 5; j++) `CHK("ind", xp[j], got[j])
    endtask
    initial begin
        #160000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        time t0;
        void'($urandom(50));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        pulse(1);
        hold(4);
        dly = 8'(6 + $urandom % 8);
        t0 = $time;
        pulse(0);
        walk('{4'h2, 4'h3, 4'h4, 4'h5, 4'h6});
        `CHK("act time", 1'b1, $time - t0 < 210000000)
        pulse(0);
        hold(6);
        frm_lost = 1'b1;
        xp[4]++;
        hold(6);
        frm_lost = 1'b0;
        quiet_req = 1'b1;
        xp[4]++;
        hold(6);
        quiet_req = 1'b0;
        pulse(1);
        walk('{4'h7, 4'h0});
        dly = 8'd40;
        t0 = $time;
        wake_req = 1'b1;
        walk('{4'h1});
        wake_req = 1'b0;
        walk('{4'h3, 4'h4, 4'h5, 4'h6});
        `CHK("wake act time", 1'b1, $time - t0 < 1500000000)
        pulse(1);
        walk('{4'h7, 4'h0});
        dly = 8'(6 + $urandom % 8);
        pulse(2);
        walk('{4'h8, 4'h9, 4'hA, 4'hB});
        pulse(1);
        walk('{4'h7});
        // Loop request from pending starts no loop wake timer: it stays
        pulse(2);
        walk('{4'h8});
        hold(40);
        pulse(1);
        walk('{4'h7, 4'h0});
        dly = 8'd40;
        for (int k = 0; k < 2; k++) begin
            pulse(0);
            walk('{4'h2});
            if (k == 1)
                walk('{4'h3});
            pulse(2);
            walk('{4'h9, 4'hA, 4'hB});
            pulse(1);
            walk('{4'h7, 4'h0});
        end
        chk_ind();
        tally_and_finish();
    end
endmodule // tb_top
bind line_term_activation_fsm line_term_fsm_chk #(
    .WAKE_ACK_CYCLES (WAKE_ACK_CYCLES),
    .PREACT_CYCLES   (PREACT_CYCLES),
    .LOOP_WAKE_CYCLES(LOOP_WAKE_CYCLES)
) line_term_fsm_chk_inst (
    .core_clk_i                  (core_clk_i),
    .rst_i                       (rst_i),
    .activate_request_element_i  (activate_request_element_i),
    .deactivate_request_element_i(deactivate_request_element_i),
    .loop1_request_element_i     (loop1_request_element_i),
    .remote_wake_signal_i        (remote_wake_signal_i),
    .framing_lost_i              (framing_lost_i),
    .tx_signal_o                 (tx_signal_o),
    .state_o                     (state_o),
    .loopback1_o                 (loopback1_o),
    .activated_indication_o      (activated_indication_o),
    .deactivated_indication_o    (deactivated_indication_o),
    .line_error_indication_o     (line_error_indication_o)
);
`default_nettype wire
